// *** logic/can_mode_control.sv ***
// mode control, abort, timestamp capture and acceptance masks
// assumes a classic wishbone master and a protocol engine that
// reports frame activity, abort completion and valid receptions
//
// Design decisions made here: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`include "can_mode_params.svh"

module can_mode_control #(
  parameter int NUM_MASKS = `NUM_MASKS,
  parameter int NUM_TX    = `NUM_TX_BUFS,
  parameter int TS_W      = `TS_W
) (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire can_mode_pkg::wb_req_t   wb_req,
  output      can_mode_pkg::wb_rsp_t   wb_rsp,
  input  wire logic                    frame_active,
  input  wire logic [NUM_TX-1:0]       tx_pending,
  output      logic [NUM_TX-1:0]       tx_abort,
  input  wire can_mode_pkg::rx_hdr_t   rx_hdr,
  input  wire can_mode_pkg::filt_t     filt,
  input  wire logic [1:0]              filt_mask_sel,
  output      logic                    rx_accept,
  output      logic [TS_W-1:0]         rx_timestamp,
  output      logic                    rx_timestamp_valid,
  output      logic [2:0]              mode_status,
  output      logic                    module_enable
);
  import can_mode_pkg::*;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [2:0]      mode_request_reg;
  logic [2:0]      mode_status_reg;
  logic            abort_all_request_reg;
  logic            capture_enable_reg;
  logic            module_on_reg;
  logic            stop_in_idle_reg;
  logic [4:0]      data_byte_compare_count_reg;
  logic            module_busy_reg;
  logic [31:0]     mask_reg [NUM_MASKS];
  logic [TS_W-1:0] timestamp_timer_reg;
  ctl_state_t      state_reg;
  ctl_state_t      state_next;

  logic        wb_hit;
  logic        wr_ctrl;
  logic        wr_mask;
  logic [1:0]  mask_idx;
  logic [31:0] wmask;
  logic [31:0] ctrl_rd;
  logic        in_config;
  logic        rx_accept_c;

  // control at the base, masks on a word stride above it
  function automatic logic is_mask_adr(input logic [`ADDR_W-1:0] a);
    is_mask_adr = ((a & `MASK_ADR_SEL) == `MASK0_OFFSET);
  endfunction : is_mask_adr

  assign wb_hit    = wb_req.cyc && wb_req.stb && !wb_rsp.ack;
  assign mask_idx  = wb_req.adr[`MASK_STRIDE_SH +: 2];
  assign wr_ctrl   = wb_hit && wb_req.we && (wb_req.adr == `CTRL_OFFSET);
  assign wr_mask   = wb_hit && wb_req.we && is_mask_adr(wb_req.adr);
  assign in_config = (mode_status_reg == `MODE_CONFIG);

  // byte enables expanded to a bit mask
  function automatic logic [31:0] lanes(input logic [3:0] sel);
    lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : lanes

  // masked merge of write data into a register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [31:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction : merge

  assign wmask = lanes(wb_req.sel);

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic [31:0] ctrl_new;
  assign ctrl_new = merge(ctrl_rd, wb_req.dat, wmask);

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_request_reg   <= `MODE_CONFIG;
      capture_enable_reg <= 1'b0;
      module_on_reg      <= 1'b0;
      stop_in_idle_reg   <= 1'b0;
      data_byte_compare_count_reg <= 5'h00;
    end else if (wr_ctrl) begin
      // only reserved-free codes are latched; 101 and 110 keep the old request
      if (ctrl_new[`CTRL_REQ_HI:`CTRL_REQ_LO] != `MODE_RSVD_LO &&
          ctrl_new[`CTRL_REQ_HI:`CTRL_REQ_LO] != `MODE_RSVD_HI) begin
        mode_request_reg <= ctrl_new[`CTRL_REQ_HI:`CTRL_REQ_LO];
      end
      capture_enable_reg <= ctrl_new[`CTRL_CAP_BIT];
      module_on_reg      <= ctrl_new[`CTRL_ON_BIT];
      stop_in_idle_reg   <= ctrl_new[`CTRL_IDLE_STOP_BIT];
      data_byte_compare_count_reg <= ctrl_new[`CTRL_CMP_CNT_HI:`CTRL_CMP_CNT_LO];
    end
  end

  // abort request: software sets, hardware clears; a set wins the clear
  always_ff @(posedge clk) begin
    if (srst) begin
      abort_all_request_reg <= 1'b0;
    end else if (wr_ctrl && ctrl_new[`CTRL_ABORT_BIT]) begin
      abort_all_request_reg <= 1'b1;
    end else if (abort_all_request_reg && tx_pending == '0) begin
      abort_all_request_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_abort <= '0;
    end else begin
      tx_abort <= {NUM_TX{abort_all_request_reg}} & tx_pending;
    end
  end

  // ----------------------------------------------------------------
  // enable / mode sequencing
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_OFF:   if (module_on_reg) state_next = ST_RUN;
      ST_RUN:   if (!module_on_reg) state_next = ST_DRAIN;
      ST_DRAIN: if (module_on_reg) state_next = ST_RUN;
                else if (!frame_active) state_next = ST_OFF;
      ST_ABORT: state_next = ST_OFF;
      default:  state_next = ST_OFF;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // busy while the controller is on or still finishing a frame
  always_ff @(posedge clk) begin
    if (srst) begin
      module_busy_reg <= 1'b0;
      module_enable   <= 1'b0;
    end else begin
      module_busy_reg <= (state_next != ST_OFF);
      module_enable   <= (state_next != ST_OFF);
    end
  end

  // status follows the request only between frames
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_status_reg <= `MODE_CONFIG;
    end else if (!frame_active && mode_status_reg != mode_request_reg) begin
      mode_status_reg <= mode_request_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_status <= `MODE_CONFIG;
    end else begin
      mode_status <= mode_status_reg;
    end
  end

  // ----------------------------------------------------------------
  // receive timestamp
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst || !capture_enable_reg) begin
      timestamp_timer_reg <= '0;
    end else begin
      timestamp_timer_reg <= timestamp_timer_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_timestamp       <= '0;
      rx_timestamp_valid <= 1'b0;
    end else begin
      rx_timestamp_valid <= capture_enable_reg && rx_hdr.valid && rx_accept_c;
      if (capture_enable_reg && rx_hdr.valid && rx_accept_c) begin
        rx_timestamp <= timestamp_timer_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // acceptance masks
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_MASKS; i++) begin
        mask_reg[i] <= `MASK_RESET;
      end
    end else if (wr_mask && in_config) begin
      mask_reg[mask_idx] <= merge(mask_reg[mask_idx], wb_req.dat,
                                  wmask & `MASK_WRITABLE);
    end
  end

  logic [31:0] msel;
  logic        std_ok;
  logic        ext_ok;
  logic        type_ok;

  assign msel    = mask_reg[filt_mask_sel];
  assign std_ok  = ((rx_hdr.std_id ^ filt.std_id)
                    & msel[`MASK_STD_HI:`MASK_STD_LO]) == '0;
  assign ext_ok  = !rx_hdr.ext ||
                   (((rx_hdr.ext_id ^ filt.ext_id)
                     & msel[`MASK_EXT_HI:`MASK_EXT_LO]) == '0);
  assign type_ok = !msel[`MASK_TYPE_BIT] || (rx_hdr.ext == filt.ext_sel);
  assign rx_accept_c = std_ok && ext_ok && type_ok;

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_accept <= 1'b0;
    end else begin
      rx_accept <= rx_hdr.valid && rx_accept_c;
    end
  end

  // ----------------------------------------------------------------
  // wishbone read and ack
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_rd = '0;
    ctrl_rd[`CTRL_ABORT_BIT]               = abort_all_request_reg;
    ctrl_rd[`CTRL_REQ_HI:`CTRL_REQ_LO]     = mode_request_reg;
    ctrl_rd[`CTRL_STAT_HI:`CTRL_STAT_LO]   = mode_status_reg;
    ctrl_rd[`CTRL_CAP_BIT]                 = capture_enable_reg;
    ctrl_rd[`CTRL_ON_BIT]                  = module_on_reg;
    ctrl_rd[`CTRL_IDLE_STOP_BIT]           = stop_in_idle_reg;
    ctrl_rd[`CTRL_BUSY_BIT]                = module_busy_reg;
    ctrl_rd[`CTRL_CMP_CNT_HI:`CTRL_CMP_CNT_LO] = data_byte_compare_count_reg;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wb_rsp <= '0;
    end else begin
      wb_rsp.ack <= wb_hit;
      wb_rsp.dat <= '0;
      if (wb_hit && !wb_req.we) begin
        if (wb_req.adr == `CTRL_OFFSET) begin
          wb_rsp.dat <= ctrl_rd;
        end else if (is_mask_adr(wb_req.adr)) begin
          wb_rsp.dat <= mask_reg[mask_idx];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence req_change_s;
    !frame_active && mode_status_reg != mode_request_reg;
  endsequence

  status_follow_a: assert property (@(posedge clk) disable iff (srst)
    req_change_s |=> mode_status_reg == $past(mode_request_reg))
    else $error("mode status did not take the request between frames");

  status_hold_a: assert property (@(posedge clk) disable iff (srst)
    frame_active |=> $stable(mode_status_reg))
    else $error("mode status changed during a frame");

  abort_clear_a: assert property (@(posedge clk) disable iff (srst)
    abort_all_request_reg && tx_pending == '0 && !wr_ctrl |=> !abort_all_request_reg)
    else $error("abort request not cleared once buffers idle");

  abort_drive_a: assert property (@(posedge clk) disable iff (srst)
    abort_all_request_reg && tx_pending != '0 |=> tx_abort == $past(tx_pending))
    else $error("abort not signalled to pending buffers");

  mask_lock_a: assert property (@(posedge clk) disable iff (srst)
    !in_config |=> mask_reg[0] == $past(mask_reg[0]))
    else $error("mask changed outside configuration mode");

  mask_resv_a: assert property (@(posedge clk) disable iff (srst)
    (mask_reg[0] & ~`MASK_WRITABLE) == '0)
    else $error("reserved mask bits set");

  timer_stop_a: assert property (@(posedge clk) disable iff (srst)
    !capture_enable_reg |=> timestamp_timer_reg == '0)
    else $error("timestamp timer ran while capture disabled");

  drain_wait_a: assert property (@(posedge clk) disable iff (srst)
    state_reg == ST_DRAIN && frame_active && !module_on_reg |=> module_enable)
    else $error("module disabled before frame completed");

  type_check_a: assert property (@(posedge clk) disable iff (srst)
    rx_hdr.valid && msel[`MASK_TYPE_BIT] && rx_hdr.ext != filt.ext_sel |=> !rx_accept)
    else $error("frame type mismatch accepted");

  busy_flag_a: assert property (@(posedge clk) disable iff (srst)
    state_reg == ST_DRAIN && !module_on_reg && !frame_active |=> !module_busy_reg)
    else $error("busy flag held after the last frame ended");

  rsvd_code_a: assert property (@(posedge clk) disable iff (srst)
    wr_ctrl && (ctrl_new[`CTRL_REQ_HI:`CTRL_REQ_LO] == `MODE_RSVD_LO ||
                ctrl_new[`CTRL_REQ_HI:`CTRL_REQ_LO] == `MODE_RSVD_HI)
    |=> $stable(mode_request_reg))
    else $error("reserved mode request was latched");

  status_copy_a: assert property (@(posedge clk) disable iff (srst)
    1'b1 |=> mode_status == $past(mode_status_reg))
    else $error("mode status output lags the status field");

  stamp_take_a: assert property (@(posedge clk) disable iff (srst)
    capture_enable_reg && rx_hdr.valid && rx_accept_c
    |=> rx_timestamp_valid && rx_timestamp == $past(timestamp_timer_reg))
    else $error("timestamp not captured on accepted reception");

  std_miss_a: assert property (@(posedge clk) disable iff (srst)
    rx_hdr.valid && ((rx_hdr.std_id ^ filt.std_id) & msel[`MASK_STD_HI:`MASK_STD_LO]) != '0
    |=> !rx_accept)
    else $error("standard identifier mismatch accepted");

  ext_miss_a: assert property (@(posedge clk) disable iff (srst)
    rx_hdr.valid && rx_hdr.ext
    && ((rx_hdr.ext_id ^ filt.ext_id) & msel[`MASK_EXT_HI:`MASK_EXT_LO]) != '0
    |=> !rx_accept)
    else $error("extended identifier mismatch accepted");

endmodule : can_mode_control

// *** common/can_mode_params.svh ***
// constants for the can mode control and acceptance mask block
// assumes a 32-bit classic wishbone slave, word aligned
`ifndef CAN_MODE_PARAMS_SVH
`define CAN_MODE_PARAMS_SVH

// register byte offsets (word aligned)
`define CTRL_OFFSET    6'h00
`define MASK0_OFFSET   6'h10
`define MASK_STRIDE_SH 2
`define MASK_ADR_SEL   6'h33
`define ADDR_W         6

// control register fields
`define CTRL_ABORT_BIT   27
`define CTRL_REQ_HI      26
`define CTRL_REQ_LO      24
`define CTRL_STAT_HI     23
`define CTRL_STAT_LO     21
`define CTRL_CAP_BIT     20
`define CTRL_ON_BIT      15
`define CTRL_IDLE_STOP_BIT 13
`define CTRL_BUSY_BIT    11
`define CTRL_CMP_CNT_HI  4
`define CTRL_CMP_CNT_LO  0

// mask register fields
`define MASK_STD_HI      31
`define MASK_STD_LO      21
`define MASK_TYPE_BIT    19
`define MASK_EXT_HI      17
`define MASK_EXT_LO      0
`define MASK_WRITABLE    32'hffeb_ffff

// mode codes
`define MODE_NORMAL      3'h0
`define MODE_DISABLE     3'h1
`define MODE_LOOPBACK    3'h2
`define MODE_LISTEN_ONLY 3'h3
`define MODE_CONFIG      3'h4
`define MODE_LISTEN_ALL  3'h7
`define MODE_RSVD_LO     3'h5
`define MODE_RSVD_HI     3'h6

`define MASK_RESET       32'h0000_0000
`define NUM_MASKS        4
`define NUM_TX_BUFS      8
`define TS_W             16

`endif

// *** common/can_mode_pkg.sv ***
// types shared by the can mode control block
// assumes can_mode_params.svh for numeric constants
package can_mode_pkg;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [5:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  // received frame header offered to the acceptance check
  typedef struct packed {
    logic        valid;
    logic        ext;
    logic [10:0] std_id;
    logic [17:0] ext_id;
  } rx_hdr_t;

  // one filter as seen by the acceptance check
  typedef struct packed {
    logic        ext_sel;
    logic [10:0] std_id;
    logic [17:0] ext_id;
  } filt_t;

  typedef enum logic [3:0] {
    ST_RUN    = 4'h1,
    ST_DRAIN  = 4'h2,
    ST_OFF    = 4'h4,
    ST_ABORT  = 4'h8
  } ctl_state_t;

endpackage : can_mode_pkg

// *** tb/can_far_node.sv ***
// stand-in for the protocol engine and the other nodes on the bus
// assumes the bench pulses go and load for one clk cycle each
`timescale 1ns/1ps
module can_far_node (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic [7:0]            tx_abort,
  input  wire logic                  load,
  input  wire logic [7:0]            load_bits,
  input  wire logic                  slow,
  input  wire logic                  go,
  input  wire can_mode_pkg::rx_hdr_t hdr_in,
  output      logic                  frame_active,
  output      logic [7:0]            tx_pending,
  output      can_mode_pkg::rx_hdr_t rx_hdr
);
  import can_mode_pkg::*;
  logic [3:0] frame_cnt_reg;
  logic [2:0] abort_cnt_reg;
  // ----------------------------------------
  // frame on the wire, header at its end
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      frame_cnt_reg <= 4'h0;
      rx_hdr        <= '0;
    end else begin
      // idle header toggles every cycle so a stale one is never mistaken
      if (!go && frame_cnt_reg == 4'h1) begin
        rx_hdr <= {1'b1, hdr_in[29:0]};
      end else begin
        rx_hdr <= {1'b0, ~rx_hdr[29:0]};
      end
      if (go) begin
        frame_cnt_reg <= 4'ha;
      end else if (frame_cnt_reg != 4'h0) begin
        frame_cnt_reg <= frame_cnt_reg - 4'h1;
      end
    end
  end
  assign frame_active = (frame_cnt_reg != 4'h0);
  // ----------------------------------------
  // pending buffers, slow or prompt to give up
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_pending    <= 8'h00;
      abort_cnt_reg <= 3'h0;
    end else if (load) begin
      tx_pending <= tx_pending | load_bits;
    end else if (|(tx_abort & tx_pending)) begin
      abort_cnt_reg <= abort_cnt_reg + 3'h1;
      if (!slow || abort_cnt_reg == 3'h5) begin
        tx_pending    <= tx_pending & ~tx_abort;
        abort_cnt_reg <= 3'h0;
      end
    end
  end
endmodule : can_far_node

// *** tb/tb.sv ***
// self-checking bench for the can mode control block
// assumes can_far_node stands in for the protocol engine and bus
`timescale 1ns/1ps
`include "can_mode_params.svh"
module tb;
  import can_mode_pkg::*;
  logic clk, srst, frame_active, rx_accept, rx_timestamp_valid, module_enable;
  logic load, slow, go, cap, hdr_seen;
  logic [7:0] tx_pending, tx_abort, load_bits;
  logic [1:0] filt_mask_sel;
  logic [2:0] mode_status;
  logic [15:0] rx_timestamp;
  logic [31:0] q, m[4];
  logic [2:0] codes[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h4};
  wb_req_t wb_req;
  wb_rsp_t wb_rsp;
  rx_hdr_t rx_hdr, hdr_in, h;
  filt_t filt, f;
  logic [31:0] exp_rd[$];
  logic [1:0] exp_acc[$];
  int n_mismatch, cmp_count, k, n, seed = 79;
  int cyc_cnt = 0, cyc_prev;
  logic ts_seen = 1'b0;
  logic [15:0] ts_prev;
  can_mode_control can_mode_control_i (.clk, .srst, .wb_req, .wb_rsp, .frame_active,
    .tx_pending, .tx_abort, .rx_hdr, .filt, .filt_mask_sel, .rx_accept, .rx_timestamp,
    .rx_timestamp_valid, .mode_status, .module_enable);
  can_far_node can_far_node_i (.clk, .srst, .tx_abort, .load, .load_bits, .slow, .go,
    .hdr_in, .frame_active, .tx_pending, .rx_hdr);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  task automatic tmo(input int i);
    if (i >= 40) begin
      n_mismatch++;
      wrap_up();
    end
  endtask : tmo
  task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d);
    int i;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (wb_rsp.ack === 1'b1) break;
    end
    tmo(i);
    q = wb_rsp.dat;
    wb_req <= '0;
    @(posedge clk);
  endtask : wb
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask : rd
  task automatic kick();
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask : kick
  task automatic settle();
    int i;
    repeat (2) @(posedge clk);
    for (i = 0; i < 40 && frame_active !== 1'b0; i++) @(posedge clk);
    tmo(i);
    repeat (3) @(posedge clk);
  endtask : settle
  function automatic logic [31:0] ctl(input logic [2:0] rq, input logic cp, input logic on);
    return {5'h0, rq, 3'h0, cp, 4'h0, on, 15'h0};
  endfunction : ctl
  function automatic logic [31:0] st(input logic [2:0] s);
    return {8'h0, s, 21'h0};
  endfunction : st
  function automatic logic [5:0] ma(input int i);
    return 6'(`MASK0_OFFSET + 4 * i);
  endfunction : ma
  function automatic logic acc(input rx_hdr_t hh, input filt_t ff, input logic [31:0] mm);
    logic ok;
    ok = (((hh.std_id ^ ff.std_id) & mm[31:21]) == 11'h0);
    if (hh.ext) ok &= (((hh.ext_id ^ ff.ext_id) & mm[17:0]) == 18'h0);
    if (mm[19]) ok &= (hh.ext == ff.ext_sel);
    return ok;
  endfunction : acc
  // ----------------------------------------
  // watchers: oldest note against each result
  // ----------------------------------------
  always @(posedge clk) begin
    if (wb_rsp.ack === 1'b1 && wb_req.we === 1'b0 && exp_rd.size() != 0)
      chk(wb_rsp.dat, exp_rd.pop_front());
    if (hdr_seen && exp_acc.size() != 0)
      chk({30'h0, rx_accept, rx_timestamp_valid}, {30'h0, exp_acc.pop_front()});
    // timer counts every clock while capture stays on
    if (rx_timestamp_valid === 1'b1) begin
      if (ts_seen)
        chk({16'h0, rx_timestamp - ts_prev}, {16'h0, 16'(cyc_cnt - cyc_prev)});
      ts_seen = 1'b1;
      ts_prev = rx_timestamp;
      cyc_prev = cyc_cnt;
    end
    cyc_cnt++;
    hdr_seen = (rx_hdr.valid === 1'b1);
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    srst <= 1'b1;
    wb_req <= '0;
    {load, slow, go, cap} <= 4'h0;
    load_bits <= 8'h00;
    hdr_in <= '0;
    filt <= '0;
    filt_mask_sel <= 2'h0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(`CTRL_OFFSET, ctl(3'h4, 1'b0, 1'b0) | st(3'h4));
    for (k = 0; k < 4; k++) rd(ma(k), 32'h0);
    rd(6'h20, 32'h0);
    wr(ma(3), 32'hffff_ffff);
    rd(ma(3), 32'hffeb_ffff);
    for (k = 0; k < 4; k++) begin
      m[k] = $random(seed) & $random(seed) & `MASK_WRITABLE;
      wr(ma(k), m[k]);
      rd(ma(k), m[k]);
    end
    wr(`CTRL_OFFSET, 32'hf4ff_7fff);
    rd(`CTRL_OFFSET, 32'h0490_201f);
    $display("reset and register access done");
    cap = 1'b1;
    foreach (codes[i]) begin
      wr(`CTRL_OFFSET, ctl(codes[i], cap, 1'b0));
      rd(`CTRL_OFFSET, ctl(codes[i], cap, 1'b0) | st(codes[i]));
      chk({29'h0, mode_status}, {29'h0, codes[i]});
    end
    for (k = 5; k < 7; k++) begin
      wr(`CTRL_OFFSET, ctl(3'(k), cap, 1'b0));
      rd(`CTRL_OFFSET, ctl(3'h4, cap, 1'b0) | st(3'h4));
    end
    kick();
    wr(`CTRL_OFFSET, ctl(3'h0, cap, 1'b0));
    rd(`CTRL_OFFSET, ctl(3'h0, cap, 1'b0) | st(3'h4));
    settle();
    rd(`CTRL_OFFSET, ctl(3'h0, cap, 1'b0));
    wr(ma(0), ~m[0]);
    wr(`CTRL_OFFSET, ctl(3'h4, cap, 1'b0));
    rd(ma(0), m[0]);
    $display("mode changes done");
    slow <= 1'b1;
    load_bits <= 8'ha5;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    wr(`CTRL_OFFSET, ctl(3'h4, cap, 1'b0) | 32'h0800_0000);
    @(negedge clk);
    chk({24'h0, tx_abort}, 32'h0000_00a5);
    @(posedge clk);
    rd(`CTRL_OFFSET, ctl(3'h4, cap, 1'b0) | st(3'h4) | 32'h0800_0000);
    for (k = 0; k < 40 && tx_pending !== 8'h00; k++) @(posedge clk);
    tmo(k);
    repeat (2) @(posedge clk);
    rd(`CTRL_OFFSET, ctl(3'h4, cap, 1'b0) | st(3'h4));
    $display("abort done");
    wr(`CTRL_OFFSET, ctl(3'h4, cap, 1'b1));
    rd(`CTRL_OFFSET, ctl(3'h4, cap, 1'b1) | st(3'h4) | 32'h800);
    chk({31'h0, module_enable}, 32'h1);
    kick();
    wr(`CTRL_OFFSET, ctl(3'h4, cap, 1'b0));
    rd(`CTRL_OFFSET, ctl(3'h4, cap, 1'b0) | st(3'h4) | 32'h800);
    // software polls busy before taking the module as off
    for (k = 0; k < 40; k++) begin
      wb(1'b0, `CTRL_OFFSET, 32'h0);
      if (q[11] === 1'b0) break;
    end
    tmo(k);
    chk({30'h0, frame_active, module_enable}, 32'h0);
    $display("module off done");
    for (n = 0; n < 32; n++) begin
      if (n == 16) begin
        cap = 1'b0;
        wr(`CTRL_OFFSET, ctl(3'h4, cap, 1'b0));
      end
      h = {1'b0, 30'($random(seed))};
      f = h[29:0] ^ 30'($random(seed) & $random(seed) & $random(seed));
      k = $random(seed) & 3;
      hdr_in <= h;
      filt <= f;
      filt_mask_sel <= 2'(k);
      exp_acc.push_back({acc(h, f, m[k]), acc(h, f, m[k]) & cap});
      kick();
      settle();
    end
    $display("acceptance done");
    chk(exp_rd.size() + exp_acc.size(), 32'h0);
    wrap_up();
  end
endmodule : tb
